// File: src/vtx_pkg.sv
/*
  Package for the VT path trace and tandem connection overhead transmitter.
  Holds register offsets, field positions, reset values, codes and the
  packed carrier for one outbound multiframe's overhead bytes.
  Assumes a 32-bit APB master and a 12-bit byte address.
*/
package vtx_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] VTX_OFF_CTRL = 12'h000;
  localparam logic [11:0] VTX_OFF_UNEQ = 12'h004;
  localparam logic [11:0] VTX_OFF_N2   = 12'h008;
  localparam logic [11:0] VTX_OFF_J2   = 12'h00C;
  localparam logic [11:0] VTX_OFF_STAT = 12'h010;
  localparam logic [11:0] VTX_OFF_IND  = 12'h014;
  localparam logic [11:0] VTX_OFF_BUF  = 12'h100;
  localparam logic [11:0] VTX_BUF_MASK = 12'hF03;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int VTX_CTRL_TC_LSB  = 6;
  localparam int VTX_CTRL_INCOMING_ALARM_BIT    = 5;
  localparam int VTX_CTRL_LEN_LSB = 2;
  localparam int VTX_CTRL_SRC_LSB = 0;
  localparam int VTX_UNEQ_PAR     = 1;
  localparam int VTX_UNEQ_PLAIN   = 0;
  localparam int VTX_N2_INCOMING_ALARM_BIT_POS  = 4;
  localparam logic [7:0] VTX_RST_BYTE = 8'h00;
  localparam logic [7:0] VTX_CTRL_WMASK = 8'hEF;
  localparam logic [7:0] VTX_UNEQ_WMASK = 8'h03;

  // ---------------------------------------------------------------
  // Codes and fixed values
  // ---------------------------------------------------------------
  localparam logic [1:0] VTX_TC_OFF   = 2'h0;
  localparam logic [1:0] VTX_TC_MSG16 = 2'h1;
  localparam logic [1:0] VTX_TC_MSG1  = 2'h3;
  localparam logic [1:0] VTX_SRC_FIX  = 2'h0;
  localparam logic [1:0] VTX_SRC_BUF  = 2'h1;
  localparam logic [1:0] VTX_SRC_REG  = 2'h2;
  localparam logic [5:0] VTX_LEN1_MASK  = 6'h00;
  localparam logic [5:0] VTX_LEN16_MASK = 6'h0F;
  localparam logic [5:0] VTX_LEN64_MASK = 6'h3F;
  localparam logic [7:0] VTX_J2_FIXED   = 8'h01;
  localparam logic [15:0] VTX_TC_FAS    = 16'hFFFE;
  localparam logic [5:0] VTX_TC_SEG_BASE = 6'h30;
  localparam int VTX_FIFO_DEPTH = 16;

  // One outbound multiframe's overhead pair
  typedef struct packed {
    logic [7:0] j2;
    logic [7:0] n2;
  } vtx_oh_t;

endpackage : vtx_pkg

// File: src/vtx_overhead_tx.sv
/*
  Transmit J2 path trace and N2 tandem connection overhead generator with
  APB register file, 64-byte trace buffer and a 16-word output FIFO.
  Assumes one clock (pclk), an APB master, and a downstream mapper that
  takes one overhead pair per outbound VT multiframe by valid/ready.
*/
`timescale 1ns/10ps

module vtx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             load;

  // Output stage is a register so the top sees flopped data
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push     = in_valid & in_ready;
  assign load     = (cnt_q != '0) & (~out_valid | out_ready);

  // Storage write
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !load)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (load && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Output register; holds while downstream stalls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_q];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end
endmodule : vtx_fifo

module vtx_overhead_tx (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  output logic                oh_valid,
  input  wire logic           oh_ready,
  output vtx_pkg::vtx_oh_t    oh_data
);
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  uneq_q;
  logic [7:0]  n2val_q;
  logic [7:0]  j2val_q;
  logic [1:0]  ind_q;
  logic [7:0]  tbuf [64];
  logic        wr_en;
  logic        setup;
  logic [5:0]  bidx;

  function automatic logic f_is_buf(input logic [11:0] a);
    f_is_buf = ((a & vtx_pkg::VTX_BUF_MASK) == vtx_pkg::VTX_OFF_BUF);
  endfunction : f_is_buf

  function automatic logic f_is_reg(input logic [11:0] a);
    f_is_reg = (a == vtx_pkg::VTX_OFF_CTRL) || (a == vtx_pkg::VTX_OFF_UNEQ)
            || (a == vtx_pkg::VTX_OFF_N2) || (a == vtx_pkg::VTX_OFF_J2)
            || (a == vtx_pkg::VTX_OFF_STAT) || (a == vtx_pkg::VTX_OFF_IND);
  endfunction : f_is_reg

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign bidx  = paddr[7:2];

  // Writes land only at the completing access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= vtx_pkg::VTX_RST_BYTE;
      uneq_q  <= vtx_pkg::VTX_RST_BYTE;
      n2val_q <= vtx_pkg::VTX_RST_BYTE;
      j2val_q <= vtx_pkg::VTX_RST_BYTE;
      ind_q   <= 2'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        vtx_pkg::VTX_OFF_CTRL:
          ctrl_q <= pwdata[7:0] & vtx_pkg::VTX_CTRL_WMASK;
        vtx_pkg::VTX_OFF_UNEQ:
          uneq_q <= pwdata[7:0] & vtx_pkg::VTX_UNEQ_WMASK;
        vtx_pkg::VTX_OFF_N2:  n2val_q <= pwdata[7:0];
        vtx_pkg::VTX_OFF_J2:  j2val_q <= pwdata[7:0];
        vtx_pkg::VTX_OFF_IND: ind_q   <= pwdata[1:0];
        default:              ind_q   <= ind_q;
      endcase
    end
  end

  // Trace buffer; no reset, software loads it before use
  always_ff @(posedge pclk)
  begin
    if (wr_en && f_is_buf(paddr))
    begin
      tbuf[bidx] <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Overhead generator
  // ---------------------------------------------------------------
  logic [1:0]  tc_mode;
  logic [1:0]  tr_len;
  logic [1:0]  tr_src;
  logic        incoming_alarm_bit;
  logic        tc_on;
  logic        uneq_par;
  logic        uneq_any;
  logic [5:0]  tr_mask;
  logic [5:0]  tr_idx_q;
  logic [3:0]  tc_slot_q;
  logic [3:0]  msg_idx_q;
  logic [1:0]  bip_q;
  logic [7:0]  msg_byte;
  logic        msg_bit;
  logic [7:0]  gen_j2;
  logic [7:0]  gen_n2;
  logic        gen_ready;
  logic        push;
  logic [7:0]  pair_x;

  assign tc_mode  = ctrl_q[vtx_pkg::VTX_CTRL_TC_LSB +: 2];
  assign tr_len   = ctrl_q[vtx_pkg::VTX_CTRL_LEN_LSB +: 2];
  assign tr_src   = ctrl_q[vtx_pkg::VTX_CTRL_SRC_LSB +: 2];
  assign incoming_alarm_bit     = ctrl_q[vtx_pkg::VTX_CTRL_INCOMING_ALARM_BIT];
  assign tc_on    = (tc_mode == vtx_pkg::VTX_TC_MSG16)
                 || (tc_mode == vtx_pkg::VTX_TC_MSG1);
  assign uneq_par = uneq_q[vtx_pkg::VTX_UNEQ_PAR];
  assign uneq_any = uneq_par | uneq_q[vtx_pkg::VTX_UNEQ_PLAIN];
  assign push     = gen_ready;  // Generator always has a frame ready
  assign pair_x   = gen_j2 ^ gen_n2;

  // Length select: 00 one byte, 01 sixteen, 1X sixty-four
  always_comb
  begin
    case (tr_len)
      2'h0:    tr_mask = vtx_pkg::VTX_LEN1_MASK;
      2'h1:    tr_mask = vtx_pkg::VTX_LEN16_MASK;
      default: tr_mask = vtx_pkg::VTX_LEN64_MASK;
    endcase
  end

  // Message byte: shared buffer segment or software N2 byte
  always_comb
  begin
    if (tc_mode == vtx_pkg::VTX_TC_MSG16)
    begin
      msg_byte = tbuf[vtx_pkg::VTX_TC_SEG_BASE | {2'h0, msg_idx_q}];
    end
    else
    begin
      msg_byte = n2val_q;
    end
    msg_bit = msg_byte[3'h7 - tc_slot_q[2:0]];
  end

  // J2 source select; code 11 is not to be used, falls back to fixed
  always_comb
  begin
    case (tr_src)
      vtx_pkg::VTX_SRC_BUF: gen_j2 = tbuf[tr_idx_q];
      vtx_pkg::VTX_SRC_REG: gen_j2 = j2val_q;
      default:              gen_j2 = vtx_pkg::VTX_J2_FIXED;
    endcase
  end

  // N2 assembly; whole frame built from one snapshot in one cycle
  always_comb
  begin
    if (uneq_any)
    begin
      // Unequipped: bit 5 low marks it; parity bit wins over plain
      gen_n2 = {uneq_par ? bip_q : 2'h0, 1'b0, 5'h00};
    end
    else if (tc_on)
    begin
      // BIP, fixed one, alarm, REI, ODI or RDI, alignment, message
      gen_n2 = {bip_q, 1'b1, 1'b0, 1'b0, ind_q[0] | ind_q[1],
                vtx_pkg::VTX_TC_FAS[4'hF - tc_slot_q], msg_bit};
    end
    else
    begin
      gen_n2 = n2val_q;
    end
    gen_n2[vtx_pkg::VTX_N2_INCOMING_ALARM_BIT_POS] = incoming_alarm_bit;
  end

  // Counters advance once per multiframe boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tr_idx_q  <= '0;
      tc_slot_q <= '0;
      msg_idx_q <= '0;
      bip_q     <= 2'h0;
    end
    else if (push)
    begin
      tr_idx_q <= (tr_idx_q + 1'b1) & tr_mask;
      bip_q    <= {^{pair_x[7], pair_x[5], pair_x[3], pair_x[1]},
                   ^{pair_x[6], pair_x[4], pair_x[2], pair_x[0]}};
      if (tc_on)
      begin
        tc_slot_q <= tc_slot_q + 1'b1;
        if (tc_slot_q[2:0] == 3'h7)
        begin
          msg_idx_q <= msg_idx_q + 1'b1;
        end
      end
      else
      begin
        tc_slot_q <= '0;
        msg_idx_q <= '0;
      end
    end
  end

  vtx_fifo #(
    .WIDTH (16),
    .DEPTH (vtx_pkg::VTX_FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (1'b1),
    .in_ready  (gen_ready),
    .in_data   ({gen_j2, gen_n2}),
    .out_valid (oh_valid),
    .out_ready (oh_ready),
    .out_data  (oh_data)
  );

  // ---------------------------------------------------------------
  // APB answer: no wait states, flopped data and error
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~f_is_reg(paddr) & ~f_is_buf(paddr);
      if (setup && !pwrite)
      begin
        if (f_is_buf(paddr))
        begin
          prdata <= {24'h00_0000, tbuf[bidx]};
        end
        else
        begin
          case (paddr)
            vtx_pkg::VTX_OFF_CTRL: prdata <= {24'h00_0000, ctrl_q};
            vtx_pkg::VTX_OFF_UNEQ: prdata <= {24'h00_0000, uneq_q};
            vtx_pkg::VTX_OFF_N2:   prdata <= {24'h00_0000, n2val_q};
            vtx_pkg::VTX_OFF_J2:   prdata <= {24'h00_0000, j2val_q};
            vtx_pkg::VTX_OFF_STAT:
              prdata <= {16'h0000, msg_idx_q, tc_slot_q, 2'h0, tr_idx_q};
            vtx_pkg::VTX_OFF_IND:  prdata <= {30'h0000_0000, ind_q};
            default:               prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_incoming_alarm_bit;
    push |-> gen_n2[4] == ctrl_q[5];
  endproperty
  a_incoming_alarm_bit: assert property (p_incoming_alarm_bit) else $error("N2 bit 4 wrong");

  property p_n2_off;
    push && tc_mode == 2'h0 && uneq_q == 8'h00
      |-> gen_n2 == {n2val_q[7:5], ctrl_q[5], n2val_q[3:0]};
  endproperty
  a_n2_off: assert property (p_n2_off) else $error("N2 not reg");

  property p_j2_fix;
    push && ctrl_q[1:0] == 2'h0 |-> gen_j2 == 8'h01;
  endproperty
  a_j2_fix: assert property (p_j2_fix) else $error("J2 not 01");

  property p_j2_reg;
    push && ctrl_q[1:0] == 2'h2 |-> gen_j2 == j2val_q;
  endproperty
  a_j2_reg: assert property (p_j2_reg) else $error("J2 not reg");

  property p_len16;
    push && ctrl_q[3:2] == 2'h1 && tr_idx_q == 6'h0F
      |=> tr_idx_q == 6'h00;
  endproperty
  a_len16: assert property (p_len16) else $error("Len wrap");

  property p_len1;
    ctrl_q[3:2] == 2'h0 && push |=> tr_idx_q == 6'h00;
  endproperty
  a_len1: assert property (p_len1) else $error("Len 1 idx");

  property p_uneq_par;
    push && uneq_q[1] |-> gen_n2[7:6] == bip_q && !gen_n2[5];
  endproperty
  a_uneq_par: assert property (p_uneq_par) else $error("Uneq bip");

  property p_uneq_plain;
    push && uneq_q[1:0] == 2'h1 |-> gen_n2[7:5] == 3'h0;
  endproperty
  a_uneq_plain: assert property (p_uneq_plain) else $error("Uneq");

  property p_tc_mark;
    push && tc_on && uneq_q[1:0] == 2'h0 |-> gen_n2[5];
  endproperty
  a_tc_mark: assert property (p_tc_mark) else $error("TC mark");

  property p_apb;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("APB pready timing");

  c_tc16: cover property (push && tc_mode == 2'h1 && tc_slot_q == 4'hF);
  c_uneq: cover property (push && uneq_q[1:0] == 2'h3);
  c_full: cover property (!gen_ready ##1 oh_valid && oh_ready);
endmodule : vtx_overhead_tx

// File: sim/vtx_sink.sv
/*
  Downstream mapper model: takes overhead pairs by valid/ready.
  Assumes the generator's pclk/presetn; stall is held by the bench.
*/
`timescale 1ns/10ps

module vtx_sink (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stall,
  input  wire logic oh_valid,
  output logic      oh_ready
);
  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  // Random gaps so the generator meets back-pressure, not only flow
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      oh_ready <= 1'b0;
    else
      oh_ready <= !stall && ($urandom % 4 != 0);
endmodule : vtx_sink

// File: sim/vtx_overhead_tx_tb.sv
/*
  Self-checking bench for the overhead transmitter: APB master tasks,
  downstream model with stalls, frame capture and comparisons.
  Assumes the package, design and sink model are compiled first.
*/
`timescale 1ns/10ps

module vtx_overhead_tx_tb;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             oh_valid;
  logic             oh_ready;
  logic             stall;
  vtx_pkg::vtx_oh_t oh_data;
  vtx_pkg::vtx_oh_t hold;
  vtx_pkg::vtx_oh_t q[$];
  int               err_total;
  int               checks_done;
  logic [31:0]      rdv;
  logic             rde;
  logic [7:0]       n2v;
  logic [7:0]       j2v;
  logic [7:0]       mk;
  logic [1:0]       b;
  logic             seen;

  vtx_overhead_tx dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oh_valid(oh_valid), .oh_ready(oh_ready), .oh_data(oh_data));
  vtx_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall),
    .oh_valid(oh_valid), .oh_ready(oh_ready));

  // ----------------------------------------------------------------
  // Clock, capture and watchdog
  // ----------------------------------------------------------------
  always #12.5 pclk = ~pclk;
  // Every pair handed over, in order
  always @(posedge pclk)
    if (presetn && oh_valid === 1'b1 && oh_ready === 1'b1)
      q.push_back(oh_data);
  // Whole run needs under two thousand cycles
  initial
  begin
    #(25 * 40000);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Holds the request until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED apb answer expected 1 seen %b", pready);
    end
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Queued frames carry old settings, so skip them before collecting
  task automatic grab(int skip, int n);
    int k;
    k = 0;
    q.delete();
    while (q.size() < skip + n && k < 4000)
    begin
      @(posedge pclk);
      k++;
    end
    if (q.size() < skip + n)
    begin
      err_total++;
      $display("CHECK FAILED frame count expected %0d seen %0d",
               skip + n, q.size());
      for (int f = q.size(); f < skip + n; f++)
        q.push_back('x);
    end
    repeat (skip) void'(q.pop_front());
  endtask : grab

  function automatic logic [7:0] j2e(int s);
    return (s == 2) ? j2v : (s == 1) ? 8'h40 : 8'h01;
  endfunction : j2e

  function automatic logic [1:0] bip(vtx_pkg::vtx_oh_t p);
    logic [7:0] x;
    x = p.j2 ^ p.n2;
    return {^{x[7], x[5], x[3], x[1]}, ^{x[6], x[4], x[2], x[0]}};
  endfunction : bip

  // Fields fixed in both messaging modes, then bit counts per window
  task automatic tc_check(int ones_msg);
    int o1;
    int o0;
    o1 = 0;
    o0 = 0;
    foreach (q[i])
    begin
      chk("tc n2 bits", 4'hD, q[i].n2[5:2]);
      o1 += q[i].n2[1];
      if (i < 8)
        o0 += q[i].n2[0];
    end
    chk("alignment ones", 15, o1);
    chk("message ones", ones_msg, o0);
  endtask : tc_check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; stall = 0; err_total = 0; checks_done = 0;
    void'($urandom(32'hC420));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped access, reserved control bit
    for (int a = 0; a < 16; a += 4)
    begin
      apb(0, 12'(a), 0);
      chk("reset value", 0, rdv);
    end
    apb(1, 12'h020, 32'hFF);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, rde);
    chk("unmapped data", 0, rdv);
    apb(1, vtx_pkg::VTX_OFF_CTRL, 32'hFE);
    apb(0, vtx_pkg::VTX_OFF_CTRL, 0);
    chk("ctrl readback", 32'hEE, rdv);
    for (int i = 0; i < 64; i++)
      apb(1, 12'(12'h100 + 4 * i), 32'(8'h40 + i));
    n2v = 8'($urandom);
    j2v = 8'($urandom) | 8'h80;
    apb(1, vtx_pkg::VTX_OFF_N2, 32'(n2v));
    apb(1, vtx_pkg::VTX_OFF_J2, 32'(j2v));
    // Trace sources with tandem off; alarm bit toggled per source
    for (int s = 0; s < 3; s++)
    begin
      apb(1, vtx_pkg::VTX_OFF_CTRL, 32'({2'b00, s[0], 3'b000, s[1:0]}));
      grab(20, 4);
      foreach (q[i])
      begin
        chk("j2 source", j2e(s), q[i].j2);
        chk("n2 off", {n2v[7:5], s[0], n2v[3:0]}, q[i].n2);
      end
    end
    // Trace lengths: buffer index steps modulo the length
    for (int l = 0; l < 4; l++)
    begin
      apb(1, vtx_pkg::VTX_OFF_CTRL, 32'({4'h0, l[1:0], 2'b01}));
      grab(20, 70);
      mk = (l == 0) ? 8'h00 : (l == 1) ? 8'h0F : 8'h3F;
      for (int i = 1; i < 70; i++)
        chk("j2 step", ((q[i-1].j2 - 8'h3F) & mk) + 8'h40,
            q[i].j2);
    end
    // Unequipped plain, with parity, both; varying j2 drives parity
    apb(1, vtx_pkg::VTX_OFF_CTRL, 32'h29);
    for (int u = 1; u < 4; u++)
    begin
      apb(1, vtx_pkg::VTX_OFF_UNEQ, 32'(u));
      grab(20, 8);
      for (int i = 1; i < 8; i++)
      begin
        b = (u == 1) ? 2'b00 : bip(q[i-1]);
        chk("uneq low", 6'h10, q[i].n2[5:0]);
        chk("uneq parity", 1, q[i].n2[7:6] === b ||
            q[i].n2[7:6] === {b[0], b[1]});
      end
    end
    apb(1, vtx_pkg::VTX_OFF_UNEQ, 0);
    grab(20, 2);
    chk("uneq off", {n2v[7:5], 1'b1, n2v[3:0]}, q[0].n2);
    // Tandem 1-byte then 16-byte messaging, ODI raised
    apb(1, vtx_pkg::VTX_OFF_IND, 1);
    apb(1, vtx_pkg::VTX_OFF_CTRL, 32'hE0);
    grab(20, 16);
    tc_check($countones(n2v));
    apb(1, vtx_pkg::VTX_OFF_N2, 0);
    for (int i = 48; i < 64; i++)
      apb(1, 12'(12'h100 + 4 * i), 32'hFF);
    apb(1, vtx_pkg::VTX_OFF_CTRL, 32'h65);
    grab(20, 16);
    tc_check(8);
    // Full FIFO under stall, then a source change never mixes back
    apb(1, vtx_pkg::VTX_OFF_CTRL, 0);
    grab(20, 1);
    stall <= 1'b1;
    repeat (3) @(posedge pclk);
    hold = oh_data;
    repeat (40) @(posedge pclk);
    chk("stall valid", 1, oh_valid);
    chk("stall data", hold, oh_data);
    apb(1, vtx_pkg::VTX_OFF_CTRL, 2);
    stall <= 1'b0;
    grab(0, 30);
    seen = 0;
    foreach (q[i])
    begin
      chk("no mix", 1, q[i].j2 === j2v ||
          (q[i].j2 === 8'h01 && !seen));
      seen = seen | (q[i].j2 === j2v);
    end
    chk("new source", 1, seen);
    tally_and_finish();
  end
endmodule : vtx_overhead_tx_tb
